// ---- shared/sdo_tunnel_regs.vh ----
// constants of the indirect register access unit
// assumes a 25 MHz core clock; included by bare name from rtl files
`ifndef SDO_TUNNEL_REGS_VH
`define SDO_TUNNEL_REGS_VH

// object dictionary entry of the access word
`define OBJ_INDEX 16'h4500
`define OBJ_SUBINDEX 8'h00

// access word field layout (bit positions)
`define WORD_FLAG_BIT 31
`define WORD_TABLE_HI 30
`define WORD_TABLE_LO 24
`define WORD_REG_HI 23
`define WORD_REG_LO 16
`define WORD_VALUE_HI 15
`define WORD_VALUE_LO 0

// table numbers
`define TBL_CONFIG 7'h00
`define TBL_IDENT 7'h09
`define TBL_UNLOCK 7'h63
`define TBL_BAUD 7'h64

// register numbers inside tables
`define REG_TBUS_CONFIG 8'h02
`define REG_BAUD_INDEX 8'h03
`define REG_STATION_ID 8'h00
`define REG_UNLOCK_STEP1 8'h02
`define REG_UNLOCK_STEP2 8'h01
`define REG_UNLOCK_STEP3 8'h00

// unlock code words, in order
`define UNLOCK_WORD1 16'hAFFE
`define UNLOCK_WORD2 16'h0001
`define UNLOCK_WORD3 16'h0101

// terminal-bus configuration word fields and reset value
`define CFG_AUTO_RESTART_BIT 0
`define CFG_DIAG_ENABLE_BIT 1
`define CFG_IMAGE_DIAG_BIT 2
`define CFG_WIDTH 3
`define CFG_RESET 3'h6

// baud rate index table, reset value is index 4 (125 kbit/s)
`define BAUD_RESET 8'h04

// digital terminal identifier layout
`define IDENT_DIGITAL_BIT 15
`define IDENT_OUT_BIT 1
`define IDENT_IN_BIT 0

// abort codes returned in place of a confirmation
`define ABORT_NO_OBJECT 32'h06020000
`define ABORT_READ_ONLY 32'h06010002
`define ABORT_NOT_MAPPABLE 32'h06040041
`define ABORT_NO_DATA 32'h08000020

// terminal-bus restart interval
`define CLOCK_HZ 25000000
`define RESTART_INTERVAL_MS 100
`define RESTART_CYCLES (`RESTART_INTERVAL_MS * (`CLOCK_HZ / 1000))

`endif

// ---- rtl/unlock_sequencer.v ----
// three-step write protection release for the configuration tables
// assumes i_write is a one-cycle pulse per access-word write to the unlock table
`include "sdo_tunnel_regs.vh"

module unlock_sequencer (
    input wire i_clock,
    input wire i_rst,
    input wire i_write,
    input wire [7:0] i_reg,
    input wire [15:0] i_value,
    output reg o_unlocked
);

    localparam ST_IDLE = 2'b00;
    localparam ST_GOT1 = 2'b01;
    localparam ST_GOT2 = 2'b10;

    reg [1:0] step;

    ////////////////////////////////////////////////////////////////////////
    // any out-of-order write restarts the sequence from step one
    always @(posedge i_clock) begin
        if (i_rst) begin
            step <= ST_IDLE;
            o_unlocked <= 1'b0;
        end else if (i_write) begin
            case (step)
                ST_IDLE: begin
                    if (i_reg == `REG_UNLOCK_STEP1 && i_value == `UNLOCK_WORD1) begin
                        step <= ST_GOT1;
                    end
                end
                ST_GOT1: begin
                    if (i_reg == `REG_UNLOCK_STEP2 && i_value == `UNLOCK_WORD2) begin
                        step <= ST_GOT2;
                    end else begin
                        step <= ST_IDLE;
                    end
                end
                ST_GOT2: begin
                    step <= ST_IDLE;
                    if (i_reg == `REG_UNLOCK_STEP3 && i_value == `UNLOCK_WORD3) begin
                        o_unlocked <= 1'b1;
                    end
                end
                default: begin
                    step <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- rtl/terminal_ident_encoder.v ----
// builds the 16-bit identifier of one attached terminal
// purely combinational; the caller registers the result
`include "sdo_tunnel_regs.vh"

module terminal_ident_encoder (
    input wire i_digital,
    input wire [6:0] i_width,
    input wire i_is_output,
    input wire i_is_input,
    input wire [15:0] i_type_number,
    output reg [15:0] o_ident
);

    ////////////////////////////////////////////////////////////////////////
    // digital: marker, width, direction bits; others: plain type number
    always @* begin
        if (i_digital) begin
            o_ident = 16'h0000;
            o_ident[`IDENT_DIGITAL_BIT] = 1'b1;
            o_ident[14:8] = i_width;
            o_ident[`IDENT_OUT_BIT] = i_is_output;
            o_ident[`IDENT_IN_BIT] = i_is_input;
        end else begin
            o_ident = i_type_number;
        end
    end

endmodule

// ---- rtl/sdo_register_tunnel.v ----
// indirect register access unit behind the 32-bit access object
// assumes an sdo layer on the same clock presenting one request per cycle
`include "sdo_tunnel_regs.vh"

module sdo_register_tunnel #(
    parameter [15:0] STATION_ID = 16'h1234, // arbitrary value
    parameter RESTART_CYCLES = `RESTART_CYCLES
) (
    input wire i_clock,
    input wire i_rst,
    input wire i_req_download,
    input wire i_req_upload,
    input wire i_req_map,
    input wire [15:0] i_req_index,
    input wire [7:0] i_req_subindex,
    input wire [31:0] i_req_bytes,
    input wire i_ident_load,
    input wire [7:0] i_ident_slot,
    input wire i_ident_digital,
    input wire [6:0] i_ident_width,
    input wire i_ident_is_output,
    input wire i_ident_is_input,
    input wire [15:0] i_ident_type,
    input wire i_tbus_fault,
    input wire i_terminal_fault,
    input wire [15:0] i_fault_code,
    output reg o_rsp_valid,
    output reg o_rsp_abort,
    output reg [31:0] o_rsp_bytes,
    output reg [31:0] o_abort_code,
    output reg o_unlocked,
    output reg o_auto_restart,
    output reg o_diag_enable,
    output reg o_diag_in_image,
    output reg [7:0] o_baud_index,
    output reg o_tbus_reset,
    output reg o_emcy_valid,
    output reg [15:0] o_emcy_code
);

    // fetch sequencing after a selecting download
    localparam FETCH_IDLE = 2'b00;
    localparam FETCH_READ = 2'b01;
    localparam FETCH_DONE = 2'b10;

    ////////////////////////////////////////////////////////////////////////
    // request decode

    wire obj_hit;
    wire [31:0] word;
    wire acc_flag;
    wire [6:0] acc_table;
    wire [7:0] acc_reg;
    wire [15:0] acc_value;
    wire unlock_wr;
    wire unlocked;
    wire [15:0] new_ident;

    // byte 0 arrives first and lands in the low lane, byte 3 last
    assign word = {i_req_bytes[31:24], i_req_bytes[23:16],
                   i_req_bytes[15:8], i_req_bytes[7:0]};
    assign obj_hit = (i_req_index == `OBJ_INDEX) &&
                     (i_req_subindex == `OBJ_SUBINDEX);
    assign acc_flag = word[`WORD_FLAG_BIT];
    assign acc_table = word[`WORD_TABLE_HI:`WORD_TABLE_LO];
    assign acc_reg = word[`WORD_REG_HI:`WORD_REG_LO];
    assign acc_value = word[`WORD_VALUE_HI:`WORD_VALUE_LO];
    assign unlock_wr = i_req_download && obj_hit && acc_flag &&
                       (acc_table == `TBL_UNLOCK);

    ////////////////////////////////////////////////////////////////////////
    // helpers: protection sequence and terminal identifier builder

    unlock_sequencer u_unlock (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(unlock_wr),
        .i_reg(acc_reg),
        .i_value(acc_value),
        .o_unlocked(unlocked)
    );

    terminal_ident_encoder u_ident (
        .i_digital(i_ident_digital),
        .i_width(i_ident_width),
        .i_is_output(i_ident_is_output),
        .i_is_input(i_ident_is_input),
        .i_type_number(i_ident_type),
        .o_ident(new_ident)
    );

    ////////////////////////////////////////////////////////////////////////
    // identifier table of attached terminals

    reg [15:0] ident_mem [0:255];
    reg [255:0] ident_present;
    reg [15:0] ident_rd;
    reg ident_rd_present;

    // slot 0 is the station itself and never stored here
    always @(posedge i_clock) begin
        if (i_ident_load && i_ident_slot != 8'h00) begin
            ident_mem[i_ident_slot] <= new_ident;
        end
    end

    // presence bits let unscanned slots read as zero, not as garbage
    always @(posedge i_clock) begin
        if (i_rst) begin
            ident_present <= 256'h0;
        end else if (i_ident_load && i_ident_slot != 8'h00) begin
            ident_present[i_ident_slot] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration state and selection

    reg [`CFG_WIDTH-1:0] cfg;
    reg [7:0] baud;
    reg [6:0] sel_table;
    reg [7:0] sel_reg;
    reg pending;
    reg [1:0] fetch;
    reg [15:0] sel_value;
    reg sel_error;

    // the value path of a select is never looked at, only table and register
    always @(posedge i_clock) begin
        if (i_rst) begin
            sel_table <= `TBL_CONFIG;
            sel_reg <= 8'h00;
            pending <= 1'b0;
            fetch <= FETCH_IDLE;
            sel_value <= 16'h0000;
            sel_error <= 1'b0;
            ident_rd <= 16'h0000;
            ident_rd_present <= 1'b0;
        end else if (i_req_download && obj_hit && !acc_flag) begin
            sel_table <= acc_table;
            sel_reg <= acc_reg;
            pending <= 1'b1;
            fetch <= FETCH_READ;
        end else begin
            case (fetch)
                FETCH_READ: begin
                    ident_rd <= ident_mem[sel_reg];
                    ident_rd_present <= ident_present[sel_reg];
                    fetch <= FETCH_DONE;
                end
                FETCH_DONE: begin
                    pending <= 1'b0;
                    fetch <= FETCH_IDLE;
                    sel_error <= 1'b0;
                    case (sel_table)
                        `TBL_CONFIG: begin
                            sel_value <= {13'h0000, cfg};
                            sel_error <= (sel_reg != `REG_TBUS_CONFIG);
                        end
                        `TBL_BAUD: begin
                            sel_value <= {8'h00, baud};
                            sel_error <= (sel_reg != `REG_BAUD_INDEX);
                        end
                        `TBL_IDENT: begin
                            if (sel_reg == `REG_STATION_ID) begin
                                sel_value <= STATION_ID;
                            end else if (ident_rd_present) begin
                                sel_value <= ident_rd;
                            end else begin
                                sel_value <= 16'h0000;
                            end
                        end
                        `TBL_UNLOCK: begin
                            // code words are write-only, reading gives zero
                            sel_value <= 16'h0000;
                            sel_error <= (sel_reg > `REG_UNLOCK_STEP1);
                        end
                        default: begin
                            sel_value <= 16'h0000;
                            sel_error <= 1'b1;
                        end
                    endcase
                end
                default: begin
                    fetch <= FETCH_IDLE;
                end
            endcase
        end
    end

    // writes to known registers; protection gates the store, and for unknown registers the no-data answer too
    always @(posedge i_clock) begin
        if (i_rst) begin
            cfg <= `CFG_RESET;
            baud <= `BAUD_RESET;
        end else if (i_req_download && obj_hit && acc_flag && unlocked) begin
            if (acc_table == `TBL_CONFIG && acc_reg == `REG_TBUS_CONFIG) begin
                cfg <= acc_value[`CFG_WIDTH-1:0];
            end
            if (acc_table == `TBL_BAUD && acc_reg == `REG_BAUD_INDEX) begin
                baud <= acc_value[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sdo answers, one cycle after the request; download wins over upload

    reg write_known;

    always @* begin
        write_known = 1'b0;
        if (acc_table == `TBL_CONFIG) begin
            write_known = (acc_reg == `REG_TBUS_CONFIG);
        end else if (acc_table == `TBL_BAUD) begin
            write_known = (acc_reg == `REG_BAUD_INDEX);
        end else if (acc_table == `TBL_UNLOCK) begin
            write_known = 1'b1;
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_rsp_valid <= 1'b0;
            o_rsp_abort <= 1'b0;
            o_rsp_bytes <= 32'h00000000;
            o_abort_code <= 32'h00000000;
        end else begin
            o_rsp_valid <= i_req_download || i_req_upload || i_req_map;
            o_rsp_abort <= 1'b0;
            o_rsp_bytes <= 32'h00000000;
            o_abort_code <= 32'h00000000;
            if (i_req_download) begin
                if (!obj_hit) begin
                    o_rsp_abort <= 1'b1;
                    o_abort_code <= `ABORT_NO_OBJECT;
                end else if (acc_flag && acc_table == `TBL_IDENT) begin
                    o_rsp_abort <= 1'b1;
                    o_abort_code <= `ABORT_READ_ONLY;
                end else if (acc_flag && !write_known && unlocked) begin
                    o_rsp_abort <= 1'b1;
                    o_abort_code <= `ABORT_NO_DATA;
                end
                // locked writes outside the identifier table fall through to a plain confirmation
            end else if (i_req_upload) begin
                if (!obj_hit) begin
                    o_rsp_abort <= 1'b1;
                    o_abort_code <= `ABORT_NO_OBJECT;
                end else if (pending) begin
                    o_rsp_bytes <= {1'b1, sel_table, sel_reg, 16'h0000};
                end else if (sel_error) begin
                    o_rsp_abort <= 1'b1;
                    o_abort_code <= `ABORT_NO_DATA;
                end else begin
                    o_rsp_bytes <= {1'b0, sel_table, sel_reg, sel_value};
                end
            end else if (i_req_map) begin
                o_rsp_abort <= 1'b1;
                o_abort_code <= `ABORT_NOT_MAPPABLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration outputs

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_unlocked <= 1'b0;
            o_auto_restart <= 1'b0;
            o_diag_enable <= 1'b0;
            o_diag_in_image <= 1'b0;
            o_baud_index <= 8'h00;
        end else begin
            o_unlocked <= unlocked;
            o_auto_restart <= cfg[`CFG_AUTO_RESTART_BIT];
            o_diag_enable <= cfg[`CFG_DIAG_ENABLE_BIT];
            o_diag_in_image <= cfg[`CFG_IMAGE_DIAG_BIT] &&
                               cfg[`CFG_DIAG_ENABLE_BIT];
            o_baud_index <= baud;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // emergency messages for terminal faults

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_emcy_valid <= 1'b0;
            o_emcy_code <= 16'h0000;
        end else begin
            o_emcy_valid <= i_terminal_fault && cfg[`CFG_DIAG_ENABLE_BIT];
            if (i_terminal_fault && cfg[`CFG_DIAG_ENABLE_BIT]) begin
                o_emcy_code <= i_fault_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // terminal-bus auto-restart

    reg fault_meta;
    reg fault_sync;
    reg [31:0] restart_count;

    // fault level comes from the terminal-bus pins, so it is synchronised
    always @(posedge i_clock) begin
        if (i_rst) begin
            fault_meta <= 1'b0;
            fault_sync <= 1'b0;
        end else begin
            fault_meta <= i_tbus_fault;
            fault_sync <= fault_meta;
        end
    end

    // one reset pulse per interval while the fault lasts; silent pulses
    // can hide lost data if nobody watches the emergency stream
    always @(posedge i_clock) begin
        if (i_rst) begin
            restart_count <= 32'h00000000;
            o_tbus_reset <= 1'b0;
        end else if (fault_sync && cfg[`CFG_AUTO_RESTART_BIT]) begin
            if (restart_count >= RESTART_CYCLES - 1) begin
                restart_count <= 32'h00000000;
                o_tbus_reset <= 1'b1;
            end else begin
                restart_count <= restart_count + 32'h00000001;
                o_tbus_reset <= 1'b0;
            end
        end else begin
            restart_count <= 32'h00000000;
            o_tbus_reset <= 1'b0;
        end
    end

endmodule

// ---- testbench/sdo_tunnel_chk.sv ----
// port assertions for the indirect register access unit
// assumes one clock and a synchronous active-high reset
`include "sdo_tunnel_regs.vh"

module sdo_tunnel_chk #(
    parameter RESTART_CYCLES = 8
) (
    input wire i_clock,
    input wire i_rst,
    input wire i_req_download,
    input wire i_req_upload,
    input wire i_req_map,
    input wire [15:0] i_req_index,
    input wire [7:0] i_req_subindex,
    input wire [31:0] i_req_bytes,
    input wire i_terminal_fault,
    input wire [15:0] i_fault_code,
    input wire o_rsp_valid,
    input wire o_rsp_abort,
    input wire [31:0] o_rsp_bytes,
    input wire [31:0] o_abort_code,
    input wire o_unlocked,
    input wire o_auto_restart,
    input wire o_diag_enable,
    input wire o_diag_in_image,
    input wire [7:0] o_baud_index,
    input wire o_tbus_reset,
    input wire o_emcy_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // request decode shared by the properties
    wire req = i_req_download | i_req_upload | i_req_map;
    wire bad = (i_req_index != `OBJ_INDEX) | (i_req_subindex != `OBJ_SUBINDEX);
    wire rw = i_req_download | i_req_upload;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////
    a_answer_next: assert property (req |=> o_rsp_valid)
        else $error("request not answered next cycle");
    a_no_spurious: assert property (!req |=> !o_rsp_valid)
        else $error("answer without request");
    a_bad_object: assert property (rw && bad |=> o_rsp_abort && o_abort_code == `ABORT_NO_OBJECT)
        else $error("wrong object not refused");
    a_map_refused: assert property (i_req_map && !rw && !bad |=> o_rsp_abort
        && o_abort_code == `ABORT_NOT_MAPPABLE)
        else $error("mapping not refused");
    a_ident_ro: assert property (i_req_download && !bad && i_req_bytes[31:24] == 8'h89
        |=> o_rsp_abort && o_abort_code == `ABORT_READ_ONLY)
        else $error("identifier table written");
    a_clean_confirm: assert property (o_rsp_valid && !o_rsp_abort |-> o_abort_code == 32'h0)
        else $error("code on a confirmation");
    a_locked_baud: assert property (o_baud_index != $past(o_baud_index)
        && $past(o_baud_index) != 8'h00 |-> o_unlocked)
        else $error("baud changed while locked");
    a_unlock_sticks: assert property (o_unlocked |=> o_unlocked)
        else $error("unlock dropped");
    a_image_gate: assert property (o_diag_in_image |-> o_diag_enable || $past(o_diag_enable))
        else $error("image diagnostics without diagnostics");
    a_emcy_follow: assert property (i_terminal_fault && o_diag_enable |=> o_emcy_valid)
        else $error("fault not reported");
    a_emcy_cause: assert property (o_emcy_valid |-> $past(i_terminal_fault))
        else $error("report without fault");
    a_restart_gap: assert property (o_tbus_reset |=> !o_tbus_reset [*7])
        else $error("restarts too close");
    a_restart_enable: assert property (o_tbus_reset |-> o_auto_restart || $past(o_auto_restart))
        else $error("restart while disabled");
    c_unlock: cover property (o_unlocked && !$past(o_unlocked));
    c_restart: cover property (o_tbus_reset);
    c_emcy: cover property (o_emcy_valid);
    c_abort: cover property (o_rsp_valid && o_rsp_abort);
endmodule

bind sdo_register_tunnel sdo_tunnel_chk #(.RESTART_CYCLES(RESTART_CYCLES)) chk_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_req_download(i_req_download),
    .i_req_upload(i_req_upload), .i_req_map(i_req_map), .i_req_index(i_req_index),
    .i_req_subindex(i_req_subindex), .i_req_bytes(i_req_bytes),
    .i_terminal_fault(i_terminal_fault), .i_fault_code(i_fault_code),
    .o_rsp_valid(o_rsp_valid), .o_rsp_abort(o_rsp_abort), .o_rsp_bytes(o_rsp_bytes),
    .o_abort_code(o_abort_code), .o_unlocked(o_unlocked), .o_auto_restart(o_auto_restart),
    .o_diag_enable(o_diag_enable), .o_diag_in_image(o_diag_in_image),
    .o_baud_index(o_baud_index), .o_tbus_reset(o_tbus_reset), .o_emcy_valid(o_emcy_valid));

// ---- testbench/sdo_master_model.sv ----
// behavioural bus master issuing one sdo request at a time
// assumes requests are taken on a rising edge and answered one cycle later
module sdo_master_model (
    input wire i_clock,
    input wire i_rsp_valid,
    input wire i_rsp_abort,
    input wire [31:0] i_rsp_bytes,
    input wire [31:0] i_abort_code,
    output logic o_dl,
    output logic o_ul,
    output logic o_map,
    output logic [15:0] o_index,
    output logic [7:0] o_sub,
    output logic [31:0] o_bytes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rsp_b;
    logic [31:0] rsp_c;
    logic rsp_ab;
    logic hung;
    logic fresh;
    // idle bus at time zero
    initial begin
        {o_dl, o_ul, o_map} = 3'h0;
        {o_index, o_sub, o_bytes} = 56'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // called at a falling edge, returns one falling edge after the answer
    task automatic xfer(input logic [1:0] k, input logic [15:0] ix, input logic [7:0] sx,
                        input logic [31:0] w);
        int n;
        o_dl = (k == 2'h0);
        o_ul = (k == 2'h1);
        o_map = (k == 2'h2);
        {o_index, o_sub} = {ix, sx};
        o_bytes = w;
        @(negedge i_clock);
        {o_dl, o_ul, o_map} = 3'h0;
        // released lines show garbage so a stale value never looks valid
        {o_index, o_sub, o_bytes} = ~{ix, sx, w};
        n = 0;
        while (i_rsp_valid !== 1'b1 && n < 4) begin
            @(negedge i_clock);
            n++;
        end
        hung = (n == 4);
        {rsp_b, rsp_ab, rsp_c} = {i_rsp_bytes, i_rsp_abort, i_abort_code};
        fresh = (i_rsp_bytes[31] == 1'b0);
        // one idle edge, so a following request never shares this time step
        @(negedge i_clock);
    endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the indirect register access unit
// assumes every request is answered one cycle after it is taken
`include "sdo_tunnel_regs.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 8;
    localparam logic [15:0] SID = 16'h5A3C; // arbitrary station identifier
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic il, idig, iout, iin, tbf, tf;
    logic [15:0] itype, fc;
    logic [7:0] islot;
    logic [6:0] iwid;
    wire dl, ul, mp, rv, ra, unl, ar, de, dii, tbr, ev;
    wire [15:0] ix, ec;
    wire [7:0] sx, baud;
    wire [31:0] wb, rb, ac;
    int failures = 0;
    int samples_checked = 0;
    int cnt;
    // 25 MHz core clock
    always #20 i_clock = ~i_clock;
    sdo_master_model m (.i_clock(i_clock), .i_rsp_valid(rv), .i_rsp_abort(ra),
        .i_rsp_bytes(rb), .i_abort_code(ac), .o_dl(dl), .o_ul(ul), .o_map(mp),
        .o_index(ix), .o_sub(sx), .o_bytes(wb));
    sdo_register_tunnel #(.STATION_ID(SID), .RESTART_CYCLES(RC)) dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_req_download(dl), .i_req_upload(ul),
        .i_req_map(mp), .i_req_index(ix), .i_req_subindex(sx), .i_req_bytes(wb),
        .i_ident_load(il), .i_ident_slot(islot), .i_ident_digital(idig),
        .i_ident_width(iwid), .i_ident_is_output(iout), .i_ident_is_input(iin),
        .i_ident_type(itype), .i_tbus_fault(tbf), .i_terminal_fault(tf),
        .i_fault_code(fc), .o_rsp_valid(rv), .o_rsp_abort(ra), .o_rsp_bytes(rb),
        .o_abort_code(ac), .o_unlocked(unl), .o_auto_restart(ar), .o_diag_enable(de),
        .o_diag_in_image(dii), .o_baud_index(baud), .o_tbus_reset(tbr),
        .o_emcy_valid(ev), .o_emcy_code(ec));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    // one access; an abort is expected exactly when a code is given
    task automatic acc(input logic [1:0] k, input logic [15:0] x, input logic [7:0] s,
                       input logic [31:0] w, input logic [31:0] eb, input logic [31:0] ecd);
        m.xfer(k, x, s, w);
        chk("answer timeout", 32'(m.hung), 32'h0);
        if (m.hung) report_and_stop();
        chk("bytes", m.rsp_b, eb);
        chk("abort", 32'(m.rsp_ab), 32'(ecd != 32'h0));
        chk("code", m.rsp_c, ecd);
        chk("fresh", 32'(m.fresh), 32'(!eb[31]));
    endtask
    task automatic dlw(input logic [31:0] w, input logic [31:0] c);
        acc(2'h0, `OBJ_INDEX, `OBJ_SUBINDEX, w, 32'h0, c);
    endtask
    task automatic up(input logic [31:0] eb, input logic [31:0] c);
        acc(2'h1, `OBJ_INDEX, `OBJ_SUBINDEX, 32'h0, eb, c);
    endtask
    // select, leave two edges, then fetch
    task automatic rd(input logic [31:0] sel, input logic [31:0] eb);
        dlw(sel, 32'h0);
        tick(1);
        up(eb, 32'h0);
    endtask
    task automatic fault_pulse(input logic [31:0] exp);
        tf = 1'b1;
        fc = 16'h5A01;
        tick(1);
        // the report pulse stands for one cycle only, look at it now
        chk("emergency", 32'(ev), exp);
        tf = 1'b0;
        tick(1);
    endtask
    task automatic count_restarts();
        cnt = 0;
        repeat (40) begin
            @(negedge i_clock);
            cnt += int'(tbr === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {il, idig, iout, iin, tbf, tf} = 6'h0;
        {itype, fc, islot, iwid} = 47'h0;
        tick(10);
        i_rst = 1'b0;
        tick(3);
        chk("baud", 32'(baud), 32'h4);
        chk("cfg", 32'({ar, de, dii}), 32'h3);
        chk("unlocked", 32'(unl), 32'h0);
        fault_pulse(32'h1);
        chk("emcy code", 32'(ec), 32'h5A01);
        dlw(32'h6403BEEF, 32'h0);
        up(32'hE4030000, 32'h0);
        up(32'h64030004, 32'h0);
        rd(32'h00020000, 32'h00020006);
        acc(2'h0, 16'h4501, 8'h00, 32'h0, 32'h0, `ABORT_NO_OBJECT);
        acc(2'h1, 16'h4500, 8'h01, 32'h0, 32'h0, `ABORT_NO_OBJECT);
        acc(2'h2, 16'h4500, 8'h00, 32'h0, 32'h0, `ABORT_NOT_MAPPABLE);
        dlw(32'h89010000, `ABORT_READ_ONLY);
        dlw(32'hE4030007, 32'h0);
        rd(32'h64030000, 32'h64030004);
        // a wrong middle code must send the sequence back to its start
        dlw(32'hE302AFFE, 32'h0);
        dlw(32'hE3010002, 32'h0);
        dlw(32'hE3000101, 32'h0);
        tick(2);
        chk("unlocked", 32'(unl), 32'h0);
        dlw(32'hE302AFFE, 32'h0);
        dlw(32'hE3010001, 32'h0);
        dlw(32'hE3000101, 32'h0);
        tick(2);
        chk("unlocked", 32'(unl), 32'h1);
        dlw(32'hE4030007, 32'h0);
        tick(1);
        chk("baud", 32'(baud), 32'h7);
        rd(32'h64030000, 32'h64030007);
        dlw(32'h8002FFFF, 32'h0);
        tick(1);
        chk("cfg", 32'({ar, de, dii}), 32'h7);
        rd(32'h00020000, 32'h00020007);
        dlw(32'h80020005, 32'h0);
        tick(1);
        chk("cfg", 32'({ar, de, dii}), 32'h4);
        fault_pulse(32'h0);
        tbf = 1'b1;
        count_restarts();
        chk("restarts", 32'(cnt >= 3), 32'h1);
        dlw(32'h80020006, 32'h0);
        count_restarts();
        chk("restarts", 32'(cnt), 32'h0);
        tbf = 1'b0;
        {islot, idig, iwid, iout, iin, il} = {8'h03, 1'b1, 7'h06, 1'b1, 1'b0, 1'b1};
        tick(1);
        {islot, idig, itype} = {8'h05, 1'b0, 16'h0457};
        tick(1);
        il = 1'b0;
        rd(32'h09030000, {16'h0903, 16'h8000 | (16'h0006 << 8) | 16'h0002});
        rd(32'h09050000, 32'h09050457);
        rd(32'h09000000, {16'h0900, SID});
        rd(32'h09070000, 32'h09070000);
        dlw(32'h22000000, 32'h0);
        tick(1);
        up(32'h0, `ABORT_NO_DATA);
        dlw(32'hA2000000, `ABORT_NO_DATA);
        report_and_stop();
    end
endmodule
